// [logic/sync_serial_pkg.sv]
package sync_serial_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFF_BAUD_CONTROL     = 8'h00;
  localparam logic [7:0] OFF_RECEIVE_STATUS   = 8'h04;
  localparam logic [7:0] OFF_BAUD_DIV_LOW     = 8'h08;
  localparam logic [7:0] OFF_BAUD_DIV_HIGH    = 8'h0C;
  localparam logic [7:0] OFF_TRANSMIT_HOLDING = 8'h10;
  localparam logic [7:0] OFF_TRANSMIT_STATUS  = 8'h14;
  localparam logic [7:0] OFF_RECEIVE_READ     = 8'h18;
  localparam logic [7:0] OFF_FLAGS            = 8'h1C;

  // baud_control fields
  localparam int BC_CLOCK_POLARITY = 4;
  localparam int BC_WIDE_DIVISOR   = 3;

  // receive_status_control fields
  localparam int RS_PORT_ENABLE    = 7;
  localparam int RS_NINE_RX        = 6;
  localparam int RS_SINGLE_RX      = 5;
  localparam int RS_CONTINUOUS_RX  = 4;
  localparam int RS_OVERRUN        = 1;
  localparam int RS_RX_NINTH       = 0;

  // transmit_status_control fields
  localparam int TS_CLOCK_SOURCE   = 7;
  localparam int TS_NINE_TX        = 6;
  localparam int TS_TX_ENABLE      = 5;
  localparam int TS_CLOCKED_MODE   = 4;
  localparam int TS_HIGH_RATE      = 2;
  localparam int TS_SHIFTER_EMPTY  = 1;
  localparam int TS_TX_NINTH       = 0;

  // flags register fields
  localparam int FL_RX_PENDING     = 0;
  localparam int FL_TX_EMPTY       = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [8:0] RST_CHAR  = 9'h000;
  localparam logic [15:0] RST_TMR  = 16'h0000;

  // Character lengths in bits
  localparam logic [3:0] BITS_NARROW = 4'h8;
  localparam logic [3:0] BITS_WIDE   = 4'h9;

  // Receive FIFO depth in characters
  localparam logic [1:0] RX_FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_TX,
    MODE_RX
  } xfer_mode_e;

endpackage

// [logic/rx_char_fifo.sv]
`timescale 1ns/100ps
module rx_char_fifo import sync_serial_pkg::*; (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       clear_i,
  input  wire logic       push_i,
  input  wire logic       pop_i,
  input  wire logic [8:0] data_i,
  // State
  output logic [8:0]      top_o,
  output logic [1:0]      count_o
);

  logic [8:0] entry1_r;

  // Entry 0 is the top character, held in the output register itself
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      top_o    <= RST_CHAR;
      entry1_r <= RST_CHAR;
      count_o  <= 2'h0;
    end else if (clear_i) begin
      top_o    <= RST_CHAR;
      entry1_r <= RST_CHAR;
      count_o  <= 2'h0;
    end else begin
      case ({push_i, pop_i})
        2'b10: begin
          if (count_o == 2'h0) begin
            top_o <= data_i;
          end else begin
            entry1_r <= data_i;
          end
          count_o <= count_o + 2'h1;
        end
        2'b01: begin
          top_o   <= entry1_r;
          count_o <= count_o - 2'h1;
        end
        2'b11: begin
          if (count_o == 2'h1) begin
            top_o <= data_i;
          end else begin
            top_o    <= entry1_r;
            entry1_r <= data_i;
          end
        end
        default: begin
          count_o <= count_o;
        end
      endcase
    end
  end

endmodule

// [logic/sync_serial_master_slave.sv]
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
// How it works
// - Clocked mode: clock-source bit 1 makes master, 0 makes slave.
// - Both receive enables clear means transmit; either set means receive.
// - Unit runs only with port enable; clearing it resets the unit.
// - No start or stop bits; only data bits go on the link.
// - One shared data line, half-duplex; never transmit and receive together.
// - Master drives clock line and enables its driver for transmit or receive.
// - Master gives exactly one clock per data bit, no extra clocks.
// - Polarity set: idle high, data on falling; clear: idle low, rising.
// - Master transmit drives data line and enables data and clock drivers.
// - Holding write starts transfer; waits for busy shifter, else moves at once.
// - Transmit bit changes on leading edge, holds until next leading edge.
// - Transmit shifter has no software address; cannot be read or written.
// - Master receive releases data line driver so partner can drive it.
// - Single receive clocks one character, then hardware clears single receive.
// - Continuous receive clocks until cleared; clearing mid-character drops it.
// - Both set: single clears after first character, continuous then rules.
// - Sample on trailing edge; full character sets pending, enters FIFO.
// - Receive pending stays set while FIFO holds an unread character.
// - Slave takes clock from the pin, driver off, one bit per clock.
// - FIFO holds two; third character sets overrun, keeps FIFO, blocks reception.
// - Overrun cleared by read in single mode, continuous clear, or port disable.
// - Nine-bit reception shifts nine bits; ninth bit readable separately.
module sync_serial_master_slave import sync_serial_pkg::*; (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Clock line pin
  input  wire logic        clock_line_i,
  output logic             clock_line_o,
  output logic             clock_line_oe_o,
  // Data line pin
  input  wire logic        data_line_i,
  output logic             data_line_o,
  output logic             data_line_oe_o
);

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr[1:0] == 2'b00) && (addr <= OFF_FLAGS);
  endfunction

  // Software-visible configuration
  logic        clock_polarity_select_r;
  logic        wide_divisor_select_r;
  logic        port_enable_r;
  logic        nine_bit_receive_enable_r;
  logic        single_receive_enable_r;
  logic        continuous_receive_enable_r;
  logic        clock_source_master_r;
  logic        nine_bit_transmit_enable_r;
  logic        transmit_enable_r;
  logic        clocked_mode_r;
  logic        high_rate_select_r;
  logic        transmit_ninth_bit_r;
  logic [7:0]  baud_divisor_low_r;
  logic [7:0]  baud_divisor_high_r;
  logic [7:0]  transmit_holding_r;

  // Unit state
  logic        holding_full_r;
  logic [8:0]  transmit_shifter_r;
  logic        shifter_full_r;
  logic [8:0]  receive_shifter_r;
  logic [3:0]  bit_count_r;
  logic        overrun_flag_r;
  logic [15:0] half_timer_r;
  logic        clock_active_r;
  logic        data_out_r;

  // Pin synchronisers
  logic        clk_meta_r;
  logic        clk_sync_r;
  logic        clk_prev_r;
  logic        data_meta_r;
  logic        data_sync_r;

  // APB
  logic        pready_r;
  logic        apb_done;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] read_mux;

  // Datapath
  logic [8:0]  fifo_top;
  logic [1:0]  fifo_count;
  logic        fifo_full;
  logic        fifo_push;
  logic        fifo_pop;
  logic        active;
  xfer_mode_e  mode;
  logic        rx_mode;
  logic        rx_ok;
  logic        run_ok;
  logic [3:0]  char_bits;
  logic        last_bit;
  logic [15:0] half_period;
  logic        master_tick;
  logic        lead;
  logic        trail;
  logic        char_done;
  logic        tx_done;
  logic        rx_done;
  logic        load_shifter;
  logic [8:0]  rx_shifted;
  logic [8:0]  rx_char;

  assign apb_done = psel_i & penable_i & pready_r;
  assign wr_stb   = apb_done & pwrite_i;
  assign rd_stb   = apb_done & ~pwrite_i;

  assign active    = port_enable_r & clocked_mode_r;
  assign rx_mode   = single_receive_enable_r | continuous_receive_enable_r;
  assign mode      = !active ? MODE_OFF : (rx_mode ? MODE_RX : MODE_TX);
  assign rx_ok     = rx_mode & ~overrun_flag_r;
  assign fifo_full = (fifo_count == RX_FIFO_DEPTH);
  assign char_bits = rx_mode ? (nine_bit_receive_enable_r ? BITS_WIDE : BITS_NARROW)
                             : (nine_bit_transmit_enable_r ? BITS_WIDE : BITS_NARROW);
  assign last_bit  = (bit_count_r == char_bits - 4'h1);

  // Master clocking: transmit runs while a character is in the shifter and transmit is enabled,
  // receive while an enable is set and no overrun blocks it
  assign run_ok = (mode == MODE_RX) ? rx_ok
                : ((mode == MODE_TX) & shifter_full_r & transmit_enable_r);
  assign half_period = wide_divisor_select_r ? {baud_divisor_high_r, baud_divisor_low_r}
                                             : {8'h00, baud_divisor_low_r};
  assign master_tick = clock_source_master_r & run_ok & (half_timer_r >= half_period);

  // Leading edge leaves idle level, trailing edge returns to it
  always_comb begin
    if (!active) begin
      lead  = 1'b0;
      trail = 1'b0;
    end else if (clock_source_master_r) begin
      lead  = master_tick & ~clock_active_r;
      trail = master_tick & clock_active_r;
    end else begin
      lead  = (clk_sync_r != clk_prev_r) & (clk_sync_r == ~clock_polarity_select_r);
      trail = (clk_sync_r != clk_prev_r) & (clk_sync_r == clock_polarity_select_r);
    end
  end

  assign char_done = trail & last_bit & (rx_mode ? rx_ok : shifter_full_r);
  assign tx_done   = char_done & ~rx_mode;
  assign rx_done   = char_done & rx_mode;
  assign load_shifter = holding_full_r & (~shifter_full_r | tx_done);

  assign rx_shifted = {data_sync_r, receive_shifter_r[8:1]};
  assign rx_char    = nine_bit_receive_enable_r ? rx_shifted : {1'b0, rx_shifted[8:1]};
  assign fifo_push  = rx_done & ~fifo_full;
  assign fifo_pop   = rd_stb & (paddr_i == OFF_RECEIVE_READ) & (fifo_count != 2'h0);

  // Two flip-flops before any logic sees a pin
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_meta_r  <= 1'b0;
      clk_sync_r  <= 1'b0;
      clk_prev_r  <= 1'b0;
      data_meta_r <= 1'b0;
      data_sync_r <= 1'b0;
    end else begin
      clk_meta_r  <= clock_line_i;
      clk_sync_r  <= clk_meta_r;
      clk_prev_r  <= clk_sync_r;
      data_meta_r <= data_line_i;
      data_sync_r <= data_meta_r;
    end
  end

  // APB answer: one wait state, then pready for one cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_r  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i & penable_i & ~pready_r) begin
      pready_r  <= 1'b1;
      prdata_o  <= read_mux;
      pslverr_o <= ~addr_mapped(paddr_i);
    end else begin
      pready_r  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
  assign pready_o = pready_r;

  // The shifter has no address of its own
  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr_i)
      OFF_BAUD_CONTROL: begin
        read_mux[BC_CLOCK_POLARITY] = clock_polarity_select_r;
        read_mux[BC_WIDE_DIVISOR]   = wide_divisor_select_r;
      end
      OFF_RECEIVE_STATUS: begin
        read_mux[RS_PORT_ENABLE]   = port_enable_r;
        read_mux[RS_NINE_RX]       = nine_bit_receive_enable_r;
        read_mux[RS_SINGLE_RX]     = single_receive_enable_r;
        read_mux[RS_CONTINUOUS_RX] = continuous_receive_enable_r;
        read_mux[RS_OVERRUN]       = overrun_flag_r;
        read_mux[RS_RX_NINTH]      = fifo_top[8];
      end
      OFF_BAUD_DIV_LOW:     read_mux[7:0] = baud_divisor_low_r;
      OFF_BAUD_DIV_HIGH:    read_mux[7:0] = baud_divisor_high_r;
      OFF_TRANSMIT_HOLDING: read_mux[7:0] = transmit_holding_r;
      OFF_TRANSMIT_STATUS: begin
        read_mux[TS_CLOCK_SOURCE]  = clock_source_master_r;
        read_mux[TS_NINE_TX]       = nine_bit_transmit_enable_r;
        read_mux[TS_TX_ENABLE]     = transmit_enable_r;
        read_mux[TS_CLOCKED_MODE]  = clocked_mode_r;
        read_mux[TS_HIGH_RATE]     = high_rate_select_r;
        read_mux[TS_SHIFTER_EMPTY] = ~shifter_full_r;
        read_mux[TS_TX_NINTH]      = transmit_ninth_bit_r;
      end
      OFF_RECEIVE_READ:     read_mux[7:0] = fifo_top[7:0];
      OFF_FLAGS: begin
        read_mux[FL_RX_PENDING] = (fifo_count != 2'h0);
        read_mux[FL_TX_EMPTY]   = ~holding_full_r;
      end
      default:              read_mux = 32'h0000_0000;
    endcase
  end

  // Configuration registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_polarity_select_r    <= 1'b0;
      wide_divisor_select_r      <= 1'b0;
      port_enable_r              <= 1'b0;
      nine_bit_receive_enable_r  <= 1'b0;
      continuous_receive_enable_r <= 1'b0;
      clock_source_master_r      <= 1'b0;
      nine_bit_transmit_enable_r <= 1'b0;
      transmit_enable_r          <= 1'b0;
      clocked_mode_r             <= 1'b0;
      high_rate_select_r         <= 1'b0;
      transmit_ninth_bit_r       <= 1'b0;
      baud_divisor_low_r         <= RST_BYTE;
      baud_divisor_high_r        <= RST_BYTE;
    end else if (wr_stb) begin
      case (paddr_i)
        OFF_BAUD_CONTROL: begin
          clock_polarity_select_r <= pwdata_i[BC_CLOCK_POLARITY];
          wide_divisor_select_r   <= pwdata_i[BC_WIDE_DIVISOR];
        end
        OFF_RECEIVE_STATUS: begin
          port_enable_r               <= pwdata_i[RS_PORT_ENABLE];
          nine_bit_receive_enable_r   <= pwdata_i[RS_NINE_RX];
          continuous_receive_enable_r <= pwdata_i[RS_CONTINUOUS_RX];
        end
        OFF_BAUD_DIV_LOW:  baud_divisor_low_r  <= pwdata_i[7:0];
        OFF_BAUD_DIV_HIGH: baud_divisor_high_r <= pwdata_i[7:0];
        OFF_TRANSMIT_STATUS: begin
          clock_source_master_r      <= pwdata_i[TS_CLOCK_SOURCE];
          nine_bit_transmit_enable_r <= pwdata_i[TS_NINE_TX];
          transmit_enable_r          <= pwdata_i[TS_TX_ENABLE];
          clocked_mode_r             <= pwdata_i[TS_CLOCKED_MODE];
          high_rate_select_r         <= pwdata_i[TS_HIGH_RATE];
          transmit_ninth_bit_r       <= pwdata_i[TS_TX_NINTH];
        end
        default: begin
          port_enable_r <= port_enable_r;
        end
      endcase
    end
  end

  // Single receive: a software write wins over the hardware clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      single_receive_enable_r <= 1'b0;
    end else if (wr_stb & (paddr_i == OFF_RECEIVE_STATUS)) begin
      single_receive_enable_r <= pwdata_i[RS_SINGLE_RX];
    end else if (rx_done) begin
      single_receive_enable_r <= 1'b0;
    end
  end

  // Overrun: hardware set wins over every clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overrun_flag_r <= 1'b0;
    end else if (rx_done & fifo_full) begin
      overrun_flag_r <= 1'b1;
    end else if (!port_enable_r) begin
      overrun_flag_r <= 1'b0;
    end else if (rd_stb & (paddr_i == OFF_RECEIVE_READ) & ~continuous_receive_enable_r) begin
      overrun_flag_r <= 1'b0;
    end else if (wr_stb & (paddr_i == OFF_RECEIVE_STATUS) & ~pwdata_i[RS_CONTINUOUS_RX]) begin
      overrun_flag_r <= 1'b0;
    end
  end

  // Holding register and transmit shifter
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transmit_holding_r <= RST_BYTE;
      holding_full_r     <= 1'b0;
      transmit_shifter_r <= RST_CHAR;
      shifter_full_r     <= 1'b0;
    end else if (!port_enable_r) begin
      holding_full_r <= 1'b0;
      shifter_full_r <= 1'b0;
    end else begin
      if (wr_stb & (paddr_i == OFF_TRANSMIT_HOLDING)) begin
        transmit_holding_r <= pwdata_i[7:0];
        holding_full_r     <= 1'b1;
      end else if (load_shifter) begin
        holding_full_r <= 1'b0;
      end
      if (load_shifter) begin
        transmit_shifter_r <= {transmit_ninth_bit_r, transmit_holding_r};
        shifter_full_r     <= 1'b1;
      end else if (tx_done) begin
        shifter_full_r <= 1'b0;
      end
    end
  end

  // Master half-period timer; stops in idle level the moment clocking is
  // no longer allowed, so no clock is ever given beyond the data bits
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_timer_r   <= RST_TMR;
      clock_active_r <= 1'b0;
    end else if (!active | ~clock_source_master_r | ~run_ok) begin
      half_timer_r   <= RST_TMR;
      clock_active_r <= 1'b0;
    end else if (master_tick) begin
      half_timer_r   <= RST_TMR;
      clock_active_r <= ~clock_active_r;
    end else begin
      half_timer_r <= half_timer_r + 16'h0001;
    end
  end

  // Bit counter and receive shifter; a receive stopped mid-character
  // loses its partial bits
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_count_r       <= 4'h0;
      receive_shifter_r <= RST_CHAR;
    end else if (!active | (rx_mode & ~rx_ok) | (~rx_mode & ~shifter_full_r)) begin
      bit_count_r <= 4'h0;
    end else if (trail & (rx_mode | shifter_full_r)) begin
      bit_count_r <= last_bit ? 4'h0 : bit_count_r + 4'h1;
      if (rx_mode) begin
        receive_shifter_r <= rx_shifted;
      end
    end
  end

  // Transmit data changes only on the leading edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_out_r <= 1'b0;
    end else if (!active) begin
      data_out_r <= 1'b0;
    end else if (lead & ~rx_mode & shifter_full_r) begin
      data_out_r <= transmit_shifter_r[bit_count_r];
    end
  end

  // Pin drivers; data line is driven only in transmit, never in receive
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_line_o    <= 1'b0;
      clock_line_oe_o <= 1'b0;
      data_line_o     <= 1'b0;
      data_line_oe_o  <= 1'b0;
    end else begin
      clock_line_o    <= clock_active_r ^ clock_polarity_select_r;
      clock_line_oe_o <= active & clock_source_master_r;
      data_line_o     <= data_out_r;
      data_line_oe_o  <= (mode == MODE_TX) & transmit_enable_r;
    end
  end

  rx_char_fifo u_rx_fifo (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .clear_i  (~port_enable_r),
    .push_i   (fifo_push),
    .pop_i    (fifo_pop),
    .data_i   (rx_char),
    .top_o    (fifo_top),
    .count_o  (fifo_count)
  );

endmodule

// [dv/sync_serial_sva.sv]
`timescale 1ns/100ps
module sync_serial_sva (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // APB
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // Pins
  input  wire logic        clock_line_o,
  input  wire logic        clock_line_oe_o,
  input  wire logic        data_line_o,
  input  wire logic        data_line_oe_o
);
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence answer_s;
    !pready_o ##1 pready_o;
  endsequence
  a_one_wait: assert property (setup_s |=> answer_s)
    else $error("APB answer not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access");
  a_idle_quiet: assert property (!psel_i |=> !pready_o)
    else $error("pready without request");
  a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error answer with data");
  a_err_once: assert property (pslverr_o |=> !pslverr_o)
    else $error("pslverr held");
  // Data may only move together with a clock pin edge, never between edges
  property data_on_clock_p;
    clock_line_oe_o && data_line_oe_o && $changed(data_line_o) |-> $changed(clock_line_o);
  endproperty
  a_pin_steady: assert property (data_on_clock_p)
    else $error("data moved without a clock pin edge");
  a_clk_oe_write: assert property ($changed(clock_line_oe_o) |-> $past(wr) || $past(wr, 2))
    else $error("clock driver moved without write");
endmodule

bind sync_serial_master_slave sync_serial_sva u_sva (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .clock_line_o(clock_line_o), .clock_line_oe_o(clock_line_oe_o),
  .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o));

// [dv/serial_partner.sv]
`timescale 1ns/100ps
module serial_partner (
  // Link wires, idle clock level and byte to send
  input  wire logic        clk_w,
  input  wire logic        dat_w,
  input  wire logic        pol_i,
  input  wire logic [7:0]  tx_i,
  // Driven levels and capture
  output logic             dat_o,
  output logic             clk_o,
  output logic [15:0]      got_o
);
  logic [2:0] idx_r;
  initial begin
    dat_o = 1'b0;
    clk_o = 1'b0;
    got_o = 16'h0000;
    idx_r = 3'h0;
  end
  // Leading edge leaves idle; extra edges would skew the capture
  always @(clk_w) begin
    if (clk_w !== pol_i) begin
      dat_o = tx_i[idx_r];
      idx_r = idx_r + 3'h1;
    end else begin
      got_o = {dat_w, got_o[15:1]};
    end
  end
  // Far master: one cycle per bit, still between frames
  task burst(input int n);
    repeat (n) begin
      #80 clk_o = ~pol_i;
      #80 clk_o = pol_i;
    end
  endtask
endmodule

// [dv/sync_serial_master_slave_test.sv]
`timescale 1ns/100ps
module sync_serial_master_slave_test;
  import sync_serial_pkg::*;
  logic        clock_i, arst_n_i, psel_i, penable_i, pwrite_i, e, pol;
  logic [7:0]  paddr_i, p_tx;
  logic [31:0] pwdata_i, prdata_o, r;
  logic        pready_o, pslverr_o, clock_line_o, clock_line_oe_o;
  logic        data_line_o, data_line_oe_o, clk_w, dat_w, p_dat, p_clk;
  logic [15:0] got;
  int          err_total, cmp_count;
  // Shared wires: whoever enables drives
  assign clk_w = clock_line_oe_o ? clock_line_o : p_clk;
  assign dat_w = data_line_oe_o ? data_line_o : p_dat;
  sync_serial_master_slave DUT (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .clock_line_i(clk_w),
    .clock_line_o(clock_line_o), .clock_line_oe_o(clock_line_oe_o), .data_line_i(dat_w),
    .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o));
  serial_partner u_p (.clk_w(clk_w), .dat_w(dat_w), .pol_i(pol), .tx_i(p_tx),
    .dat_o(p_dat), .clk_o(p_clk), .got_o(got));
  task chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("Error at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task poll(input logic [7:0] a, input int b);
    do apb(1'b0, a, 32'h0); while (r[b] !== 1'b1);
  endtask
  task give_verdict;
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    #300000;
    err_total++;
    give_verdict;
  end
  initial begin
    {arst_n_i, psel_i, penable_i, pwrite_i, pol} = 5'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    p_tx = 8'h5A;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(OFF_RECEIVE_STATUS, 32'h0);
    rd(OFF_BAUD_CONTROL, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    // Master transmit, second char queued behind the first
    wr(OFF_BAUD_DIV_LOW, 32'h7);
    wr(OFF_TRANSMIT_STATUS, 32'hB0);
    wr(OFF_RECEIVE_STATUS, 32'h80);
    repeat (2) @(posedge clock_i);
    chk({30'h0, clock_line_oe_o, data_line_oe_o}, 32'h3);
    wr(OFF_TRANSMIT_HOLDING, 32'hA5);
    wr(OFF_TRANSMIT_HOLDING, 32'h3C);
    rd(OFF_FLAGS, 32'h0);
    poll(OFF_FLAGS, FL_TX_EMPTY);
    poll(OFF_TRANSMIT_STATUS, TS_SHIFTER_EMPTY);
    chk({16'h0, got}, 32'h3CA5);
    // Master single receive
    u_p.idx_r = 3'h0;
    wr(OFF_RECEIVE_STATUS, 32'hA0);
    repeat (2) @(posedge clock_i);
    chk({31'h0, data_line_oe_o}, 32'h0);
    poll(OFF_FLAGS, FL_RX_PENDING);
    rd(OFF_RECEIVE_STATUS, 32'h80);
    rd(OFF_RECEIVE_READ, 32'h5A);
    rd(OFF_FLAGS, 32'h2);
    // Three unread single receives: overrun, cleared by a read
    repeat (3) begin
      u_p.idx_r = 3'h0;
      wr(OFF_RECEIVE_STATUS, 32'hA0);
      repeat (160) @(posedge clock_i);
    end
    rd(OFF_RECEIVE_STATUS, 32'h82);
    rd(OFF_RECEIVE_READ, 32'h5A);
    rd(OFF_RECEIVE_STATUS, 32'h80);
    rd(OFF_RECEIVE_READ, 32'h5A);
    // Continuous receive runs into overrun; single clears after the first
    u_p.idx_r = 3'h0;
    wr(OFF_RECEIVE_STATUS, 32'hB0);
    poll(OFF_FLAGS, FL_RX_PENDING);
    rd(OFF_RECEIVE_STATUS, 32'h90);
    poll(OFF_RECEIVE_STATUS, RS_OVERRUN);
    rd(OFF_RECEIVE_READ, 32'h5A);
    rd(OFF_FLAGS, 32'h3);
    rd(OFF_RECEIVE_READ, 32'h5A);
    rd(OFF_RECEIVE_STATUS, 32'h92);
    wr(OFF_RECEIVE_STATUS, 32'h80);
    rd(OFF_RECEIVE_STATUS, 32'h80);
    rd(OFF_FLAGS, 32'h2);
    // Continuous receive cut mid-character; nothing pending afterwards, clock back at idle
    u_p.idx_r = 3'h0;
    wr(OFF_RECEIVE_STATUS, 32'h90);
    repeat (60) @(posedge clock_i);
    wr(OFF_RECEIVE_STATUS, 32'h80);
    repeat (40) @(posedge clock_i);
    rd(OFF_FLAGS, 32'h2);
    chk({31'h0, clock_line_o}, 32'h0);
    // Slave receive on a far master clock
    wr(OFF_TRANSMIT_STATUS, 32'h30);
    repeat (2) @(posedge clock_i);
    chk({31'h0, clock_line_oe_o}, 32'h0);
    wr(OFF_RECEIVE_STATUS, 32'h90);
    u_p.idx_r = 3'h0;
    p_tx = 8'hC3;
    u_p.burst(8);
    poll(OFF_FLAGS, FL_RX_PENDING);
    rd(OFF_RECEIVE_READ, 32'hC3);
    // Nine-bit slave receive; ninth bit wraps to the partner's bit 0
    wr(OFF_RECEIVE_STATUS, 32'hD0);
    u_p.idx_r = 3'h0;
    u_p.burst(9);
    poll(OFF_FLAGS, FL_RX_PENDING);
    rd(OFF_RECEIVE_STATUS, 32'hD1);
    rd(OFF_RECEIVE_READ, 32'hC3);
    // Idle clock level follows polarity
    wr(OFF_RECEIVE_STATUS, 32'h80);
    wr(OFF_TRANSMIT_STATUS, 32'hB0);
    pol = 1'b1;
    wr(OFF_BAUD_CONTROL, 32'h10);
    repeat (2) @(posedge clock_i);
    chk({31'h0, clock_line_o}, 32'h1);
    give_verdict;
  end
endmodule
